// [shared/wcc_pkg.sv]
// Constants and types for the wakeup and clock source control block
package wcc_pkg;

    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_RTC_SEL = 8'h96;
    localparam logic [7:0] ADDR_IO_WAKE = 8'hC9;
    localparam logic [7:0] ADDR_SEC_INT = 8'hDF;
    // Analog state register address, presented as its own read port
    localparam logic [15:0] ADDR_ANALOG_STATE = 16'h286B;

    // Reset values and the wake enable write mask
    localparam logic [7:0] RTC_SEL_RST = 8'h00;
    localparam logic [7:0] IO_WAKE_RST = 8'h00;
    localparam logic [7:0] SEC_INT_RST = 8'h00;
    localparam logic [7:0] IO_WAKE_MASK = 8'h07;

    // Field positions
    localparam int WAKE_EP_BIT = 2;
    localparam int WAKE_P0_BIT = 1;
    localparam int WAKE_NORST_BIT = 0;
    localparam int SEC_MODE_BIT = 6;
    localparam int SEC_N_MSB = 5;
    localparam int RTC_SEL_MSB = 2;
    localparam int ANS_XFAIL_BIT = 7;

    // Wake pin edge selector codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [1:0] EDGE_FALL_ALT = 2'h3;

    // Interval codes and their length in 62.5 ms ticks
    localparam int CNT_W = 21;
    localparam logic [CNT_W-1:0] TICKS_1S = 21'h000010;
    localparam logic [CNT_W-1:0] TICKS_1MIN = 21'h0003C0;
    localparam logic [CNT_W-1:0] TICKS_1H = 21'h00E100;
    localparam logic [CNT_W-1:0] TICKS_1DAY = 21'h151800;
    localparam logic [CNT_W-1:0] TICKS_500MS = 21'h000008;
    localparam logic [CNT_W-1:0] TICKS_250MS = 21'h000004;
    localparam logic [CNT_W-1:0] TICKS_125MS = 21'h000002;
    localparam logic [CNT_W-1:0] TICKS_62MS = 21'h000001;
    localparam logic [3:0] SEC_SHIFT_ZERO = 4'h0;

    // Timing
    localparam longint CLK_PERIOD_PS = 8000;
    localparam longint TICK_TIME_PS = 64'hE8D4A5100;
    localparam int TICK_CYCLES = int'(TICK_TIME_PS / CLK_PERIOD_PS);
    localparam int PRE_W = 23;
    // RC ticks without a crystal edge before the crystal counts as stopped
    localparam logic [2:0] XTAL_TIMEOUT = 3'h4;

    typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} wcc_state_t;

endpackage

// [shared/wcc_rtc_if.sv]
// Interval configuration and wake pulse between the control block and the RTC waker
`timescale 1ns/1ps
interface wcc_rtc_if;
    logic [2:0] sel;
    logic sec_mode;
    logic [5:0] sec_n;
    logic wake;
    modport cfg_side (output sel, output sec_mode, output sec_n, input wake);
    modport wake_side (input sel, input sec_mode, input sec_n, output wake);
endinterface

// [design/wcc_rtc_wake.sv]
// RTC periodic wakeup counter
`timescale 1ns/1ps
module wcc_rtc_wake #(
    parameter int TICK_CYCLES = wcc_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    wcc_rtc_if.wake_side rif
);
    typedef struct packed {
        logic [wcc_pkg::PRE_W-1:0] pre;
        logic [wcc_pkg::CNT_W-1:0] cnt;
        logic [9:0] cfg;
        logic wake;
    } wcc_rtc_state_t;

    wcc_rtc_state_t s;
    wcc_rtc_state_t next_s;
    logic tick;
    logic [9:0] cfg_now;

    function automatic logic [wcc_pkg::CNT_W-1:0] period(
        input logic [2:0] sel, input logic sec_mode, input logic [5:0] n);
        logic [wcc_pkg::CNT_W-1:0] p;
        p = wcc_pkg::TICKS_1S;
        if (sec_mode) begin
            if (n == 6'h00) begin
                p = wcc_pkg::TICKS_62MS; // [R8]
            end else begin
                p = wcc_pkg::CNT_W'({({1'b0, n} + 7'h01), wcc_pkg::SEC_SHIFT_ZERO}); // [R7]
            end
        end else begin
            unique case (sel) // [R5]
                3'h0: p = wcc_pkg::TICKS_1S;
                3'h1: p = wcc_pkg::TICKS_1MIN;
                3'h2: p = wcc_pkg::TICKS_1H;
                3'h3: p = wcc_pkg::TICKS_1DAY;
                3'h4: p = wcc_pkg::TICKS_500MS;
                3'h5: p = wcc_pkg::TICKS_250MS;
                3'h6: p = wcc_pkg::TICKS_125MS;
                3'h7: p = wcc_pkg::TICKS_62MS;
            endcase
        end
        return p;
    endfunction

    assign cfg_now = {rif.sel, rif.sec_mode, rif.sec_n};
    assign tick = (s.pre == wcc_pkg::PRE_W'(TICK_CYCLES - 1));
    assign rif.wake = s.wake;

    always_comb begin
        next_s = s;
        next_s.wake = 1'b0;
        next_s.cfg = cfg_now;
        next_s.pre = tick ? '0 : s.pre + 1'b1;
        if (cfg_now != s.cfg) begin
            // New interval restarts the count
            next_s.cnt = '0;
            next_s.pre = '0;
        end else if (tick) begin
            if (s.cnt + 1'b1 >= period(rif.sel, rif.sec_mode, rif.sec_n)) begin
                next_s.cnt = '0;
                next_s.wake = 1'b1;
            end else begin
                next_s.cnt = s.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    wake_pulse_a: assert property (s.wake |=> !s.wake) // [R5]
        else $error("RTC wake longer than one cycle");
    fast_period_a: assert property ( // [R8]
        (rif.sec_mode && rif.sec_n == 6'h00 && $stable(cfg_now) && tick) |=> s.wake)
        else $error("Zero seconds field did not give 62.5 ms period");

endmodule // wcc_rtc_wake

// [design/wcc_top.sv]
// Sleep wakeup sources and clock domain source and gating control
// How it works
// R1: Energy pulse wakes from light Sleep only when its wake enable bit is set.
// R2: Port-0 pin edges wake only when the port-0 wake enable bit is set.
// R3: Wake without reset resumes and clears both sleep requests and control bits 6:5.
// R4: Pin wake with reset bit clear resets the system into crystal clock state.
// R5: Three-bit interval code selects 1 s, 1 min, 1 h, 1 day or 500..62.5 ms.
// R6: Software writes 0x07 to interval select before setting seconds mode.
// R7: Seconds mode wakes light Sleep every N+1 seconds for field values 1 to 63.
// R8: Seconds mode with field zero gives a 62.5 ms period.
// R9: RC clock runs always and feeds the watchdog domain.
// R10: Crystal monitor swaps RC in on crystal stop and keeps kicking crystal.
// R11: Crystal fail flag readable at bit 7 of the analog state register.
// R12: PLL follows its enable; a disabled PLL passes the crystal clock.
// R13: MCU domain picks crystal or PLL, on after reset, can be gated.
// R14: Metering domain picks crystal or PLL, on after reset, can be gated.
// R15: LCD domain gates off only when PLL feeds both MCU and metering.
// R16: Watchdog domain gates together with the MCU domain.
// R17: RTC domain is never gated.
// R18: Edge code 00/11 falling, 01 rising, 10 either edge.
// R19: Any enabled wake in Sleep turns the MCU domain back on first.
`timescale 1ns/1ps
module wcc_top #(
    parameter int TICK_CYCLES = wcc_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic energy_pulse_output,
    input wire logic wake_pin_c,
    input wire logic wake_pin_d,
    input wire logic [1:0] wake_edge_c,
    input wire logic [1:0] wake_edge_d,
    input wire logic light_sleep_request,
    input wire logic deep_sleep_request,
    input wire logic pll_enable_req,
    input wire logic mcu_sel_pll_req,
    input wire logic meter_sel_pll_req,
    input wire logic meter_gate_req,
    input wire logic lcd_gate_req,
    input wire logic rc_tick,
    input wire logic crystal_tick,
    output logic clear_sleep_ctl,
    output logic wake_resume,
    output logic wake_reset,
    output logic rtc_wake_event,
    output logic mcu_clk_en,
    output logic mcu_sel_pll,
    output logic meter_clk_en,
    output logic meter_sel_pll,
    output logic lcd_clk_en,
    output logic wdt_clk_en,
    output logic rtc_clk_en,
    output logic pll_enable,
    output logic osc_src_rc,
    output logic crystal_kick,
    output logic crystal_fail_flag,
    output logic [7:0] analog_state_reg
);
    typedef struct packed {
        wcc_pkg::wcc_state_t st;
        logic [7:0] rtc_sel;
        logic [7:0] io_wake;
        logic [7:0] sec_int;
        logic [7:0] rdata;
        logic [1:0] pin_prev;
        logic light;
        logic pin_src;
        logic fired;
        logic xseen;
        logic [2:0] mon_cnt;
        logic xfail;
    } wcc_top_state_t;

    wcc_top_state_t s;
    wcc_top_state_t next_s;

    wcc_rtc_if rif ();

    logic pin_c_hit;
    logic pin_d_hit;
    logic pin_wake;
    logic ep_wake;
    logic rtc_wake;
    logic any_wake;
    logic sleep_req;

    // Edge match for one wake pin
    function automatic logic edge_hit(
        input logic [1:0] code, input logic prev, input logic now);
        logic hit;
        hit = 1'b0;
        unique case (code) // [R18]
            wcc_pkg::EDGE_FALL, wcc_pkg::EDGE_FALL_ALT: hit = prev && !now;
            wcc_pkg::EDGE_RISE: hit = !prev && now;
            wcc_pkg::EDGE_BOTH: hit = prev != now;
        endcase
        return hit;
    endfunction

    assign rif.sel = s.rtc_sel[wcc_pkg::RTC_SEL_MSB:0];
    assign rif.sec_mode = s.sec_int[wcc_pkg::SEC_MODE_BIT];
    assign rif.sec_n = s.sec_int[wcc_pkg::SEC_N_MSB:0];

    wcc_rtc_wake #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_rtc_wake (
        .clk(clk),
        .sys_rst(sys_rst),
        .rif(rif)
    );

    assign pin_c_hit = edge_hit(wake_edge_c, s.pin_prev[0], wake_pin_c);
    assign pin_d_hit = edge_hit(wake_edge_d, s.pin_prev[1], wake_pin_d);
    assign pin_wake = s.io_wake[wcc_pkg::WAKE_P0_BIT] && (pin_c_hit || pin_d_hit); // [R2]
    // Energy pulse and RTC wake only the light Sleep state
    assign ep_wake = s.light && s.io_wake[wcc_pkg::WAKE_EP_BIT]
        && energy_pulse_output; // [R1]
    assign rtc_wake = s.light && rif.wake; // [R7]
    assign any_wake = pin_wake || ep_wake || rtc_wake;
    assign sleep_req = light_sleep_request || deep_sleep_request;

    always_comb begin
        next_s = s;
        next_s.pin_prev = {wake_pin_d, wake_pin_c};

        // Register writes
        if (sfr_wr) begin
            unique case (sfr_addr)
                wcc_pkg::ADDR_RTC_SEL: next_s.rtc_sel = sfr_wdata;
                wcc_pkg::ADDR_IO_WAKE: next_s.io_wake = sfr_wdata & wcc_pkg::IO_WAKE_MASK;
                wcc_pkg::ADDR_SEC_INT: next_s.sec_int = sfr_wdata;
                default: ;
            endcase
        end

        // Register reads, unmapped addresses return zero
        if (sfr_rd) begin
            unique case (sfr_addr)
                wcc_pkg::ADDR_RTC_SEL: next_s.rdata = s.rtc_sel;
                wcc_pkg::ADDR_IO_WAKE: next_s.rdata = s.io_wake & wcc_pkg::IO_WAKE_MASK;
                wcc_pkg::ADDR_SEC_INT: next_s.rdata = s.sec_int;
                default: next_s.rdata = 8'h00;
            endcase
        end

        // Sleep and wake sequencing
        unique case (s.st)
            wcc_pkg::ST_RUN: begin
                next_s.fired = 1'b0;
                if (sleep_req) begin
                    next_s.st = wcc_pkg::ST_SLEEP;
                    next_s.light = light_sleep_request;
                end
            end
            wcc_pkg::ST_SLEEP: begin
                if (any_wake) begin
                    next_s.st = wcc_pkg::ST_WAKE; // [R19]
                    next_s.pin_src = pin_wake;
                end
            end
            wcc_pkg::ST_WAKE: begin
                next_s.fired = 1'b1;
                if (!sleep_req) begin
                    next_s.st = wcc_pkg::ST_RUN;
                    next_s.light = 1'b0;
                    next_s.pin_src = 1'b0;
                end
            end
            default: next_s.st = wcc_pkg::ST_RUN;
        endcase

        // Crystal monitor paced by RC ticks; a crystal edge wins over the clear
        if (rc_tick) begin
            next_s.xseen = 1'b0;
            if (s.xseen) begin
                next_s.mon_cnt = 3'h0;
            end else if (s.mon_cnt != wcc_pkg::XTAL_TIMEOUT) begin
                next_s.mon_cnt = s.mon_cnt + 3'h1;
            end else begin
                next_s.xfail = 1'b1; // [R10]
            end
        end
        if (crystal_tick) begin
            next_s.xseen = 1'b1;
            next_s.xfail = 1'b0;
            next_s.mon_cnt = 3'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s.st <= wcc_pkg::ST_RUN;
            s.rtc_sel <= wcc_pkg::RTC_SEL_RST;
            s.io_wake <= wcc_pkg::IO_WAKE_RST;
            s.sec_int <= wcc_pkg::SEC_INT_RST;
            s.rdata <= 8'h00;
            s.pin_prev <= 2'h0;
            s.light <= 1'b0;
            s.pin_src <= 1'b0;
            s.fired <= 1'b0;
            s.xseen <= 1'b0;
            s.mon_cnt <= 3'h0;
            s.xfail <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign sfr_rdata = s.rdata;

    // Wake outcome, one pulse on the first cycle of the wake state
    assign wake_reset = (s.st == wcc_pkg::ST_WAKE) && !s.fired && s.pin_src
        && !s.io_wake[wcc_pkg::WAKE_NORST_BIT]; // [R4]
    assign wake_resume = (s.st == wcc_pkg::ST_WAKE) && !s.fired && !wake_reset; // [R3]
    // Held until software state shows both requests dropped
    assign clear_sleep_ctl = (s.st == wcc_pkg::ST_WAKE); // [R3]
    assign rtc_wake_event = rtc_wake;

    // Clock domain sources and gates
    assign pll_enable = pll_enable_req; // [R12]
    assign mcu_clk_en = (s.st != wcc_pkg::ST_SLEEP); // [R13] [R19]
    assign mcu_sel_pll = mcu_sel_pll_req && pll_enable_req; // [R13]
    assign meter_clk_en = !meter_gate_req; // [R14]
    assign meter_sel_pll = meter_sel_pll_req && pll_enable_req; // [R14]
    assign lcd_clk_en = !(lcd_gate_req && mcu_sel_pll && meter_sel_pll); // [R15]
    assign wdt_clk_en = mcu_clk_en; // [R9] [R16]
    assign rtc_clk_en = 1'b1; // [R17]
    assign osc_src_rc = s.xfail; // [R10]
    assign crystal_kick = s.xfail; // [R10]
    assign crystal_fail_flag = s.xfail; // [R11]
    assign analog_state_reg = {s.xfail, 7'h00}; // [R11]

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    ep_wake_a: assert property ( // [R1]
        (s.st == wcc_pkg::ST_SLEEP && s.light && s.io_wake[wcc_pkg::WAKE_EP_BIT]
            && energy_pulse_output && !pin_wake) |=> (s.st == wcc_pkg::ST_WAKE) && wake_resume)
        else $error("Enabled energy pulse did not wake");

    no_wake_a: assert property ( // [R1] [R2]
        (s.st == wcc_pkg::ST_SLEEP && !s.io_wake[wcc_pkg::WAKE_EP_BIT]
            && !s.io_wake[wcc_pkg::WAKE_P0_BIT] && !rif.wake)
        |=> s.st == wcc_pkg::ST_SLEEP)
        else $error("Sleep left without an enabled source");

    pin_wake_a: assert property ( // [R2] [R18]
        (s.st == wcc_pkg::ST_SLEEP && s.io_wake[wcc_pkg::WAKE_P0_BIT]
            && wake_edge_c == wcc_pkg::EDGE_RISE && !s.pin_prev[0] && wake_pin_c)
        |=> s.st == wcc_pkg::ST_WAKE)
        else $error("Rising pin edge did not wake");

    resume_clr_a: assert property ( // [R3]
        wake_resume |-> clear_sleep_ctl && mcu_clk_en ##1 !wake_resume)
        else $error("Resume without clearing sleep control");

    wake_rst_a: assert property ( // [R4]
        (s.st == wcc_pkg::ST_SLEEP && pin_wake && !ep_wake && !rtc_wake
            && !s.io_wake[wcc_pkg::WAKE_NORST_BIT]) |=> wake_reset && !wake_resume)
        else $error("Pin wake did not reset");

    mcu_back_a: assert property ( // [R19]
        (s.st == wcc_pkg::ST_SLEEP && any_wake) |=> mcu_clk_en && wdt_clk_en)
        else $error("MCU domain still gated after wake");

    lcd_gate_a: assert property ( // [R15]
        !lcd_clk_en |-> mcu_sel_pll && meter_sel_pll)
        else $error("LCD gated without PLL on both domains");

    wdt_tie_a: assert property ( // [R16]
        wdt_clk_en == mcu_clk_en)
        else $error("Watchdog gate differs from MCU gate");

    rtc_on_a: assert property ( // [R17]
        rtc_clk_en)
        else $error("RTC domain gated");

    xtal_fail_a: assert property ( // [R10] [R11]
        (rc_tick && !crystal_tick && !s.xseen && s.mon_cnt == wcc_pkg::XTAL_TIMEOUT)
        |=> osc_src_rc && crystal_kick && analog_state_reg[wcc_pkg::ANS_XFAIL_BIT])
        else $error("Crystal stop not flagged");

    xtal_back_a: assert property ( // [R10]
        crystal_tick |=> !crystal_fail_flag)
        else $error("Fail flag stuck after crystal edge");

    pin_reset_c: cover property (wake_reset);
    pin_resume_c: cover property (wake_resume && s.pin_src);
    ep_resume_c: cover property (s.st == wcc_pkg::ST_SLEEP && ep_wake);
    rtc_resume_c: cover property (s.st == wcc_pkg::ST_SLEEP && rtc_wake);
    xtal_fail_c: cover property ($rose(crystal_fail_flag));

endmodule // wcc_top

// [sim/wcc_mcu_model.sv]
// Software side model: SFR accesses and the RC and crystal tick sources
`timescale 1ns/1ps
module wcc_mcu_model (
    input wire logic clk,
    input wire logic crystal_running,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic rc_tick,
    output logic crystal_tick
);
    logic [3:0] div;
    initial begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        rc_tick = 1'b0;
        crystal_tick = 1'b0;
        div = 4'h0;
    end
    // RC runs free, crystal only while it oscillates
    always @(posedge clk) begin
        div <= div + 4'h1;
        rc_tick <= (div == 4'hF);
        crystal_tick <= crystal_running && (div[1:0] == 2'h1);
    end
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
        #1;
    endtask
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        sfr_addr <= ~a;
        #1;
        d = sfr_rdata;
    endtask
endmodule // wcc_mcu_model

// [sim/testbench.sv]
// Self-checking bench for the wakeup and clock source control block
`timescale 1ns/1ps
module testbench;
    localparam int TC = 4;
    logic clk, sys_rst, sfr_wr, sfr_rd, crystal_running, rc_tick, crystal_tick;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, analog_state_reg;
    logic energy_pulse_output, wake_pin_c, wake_pin_d;
    logic [1:0] wake_edge_c, wake_edge_d;
    logic light_sleep_request, deep_sleep_request, pll_enable_req;
    logic mcu_sel_pll_req, meter_sel_pll_req, meter_gate_req, lcd_gate_req;
    logic clear_sleep_ctl, wake_resume, wake_reset, rtc_wake_event, mcu_clk_en;
    logic mcu_sel_pll, meter_clk_en, meter_sel_pll, lcd_clk_en, wdt_clk_en;
    logic rtc_clk_en, pll_enable, osc_src_rc, crystal_kick, crystal_fail_flag;
    int mismatches = 0;
    int num_checks = 0;

    wcc_top #(.TICK_CYCLES(TC)) dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .energy_pulse_output(energy_pulse_output), .wake_pin_c(wake_pin_c),
        .wake_pin_d(wake_pin_d), .wake_edge_c(wake_edge_c), .wake_edge_d(wake_edge_d),
        .light_sleep_request(light_sleep_request), .deep_sleep_request(deep_sleep_request),
        .pll_enable_req(pll_enable_req), .mcu_sel_pll_req(mcu_sel_pll_req),
        .meter_sel_pll_req(meter_sel_pll_req), .meter_gate_req(meter_gate_req),
        .lcd_gate_req(lcd_gate_req), .rc_tick(rc_tick), .crystal_tick(crystal_tick),
        .clear_sleep_ctl(clear_sleep_ctl), .wake_resume(wake_resume),
        .wake_reset(wake_reset), .rtc_wake_event(rtc_wake_event), .mcu_clk_en(mcu_clk_en),
        .mcu_sel_pll(mcu_sel_pll), .meter_clk_en(meter_clk_en),
        .meter_sel_pll(meter_sel_pll), .lcd_clk_en(lcd_clk_en), .wdt_clk_en(wdt_clk_en),
        .rtc_clk_en(rtc_clk_en), .pll_enable(pll_enable), .osc_src_rc(osc_src_rc),
        .crystal_kick(crystal_kick), .crystal_fail_flag(crystal_fail_flag),
        .analog_state_reg(analog_state_reg));
    wcc_mcu_model mcu (.clk(clk), .crystal_running(crystal_running), .sfr_rdata(sfr_rdata),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .rc_tick(rc_tick), .crystal_tick(crystal_tick));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkr(input string n, input int lo, input int hi, input int v);
        num_checks++;
        if (v < lo || v > hi) begin
            mismatches++;
            $display("Error %s expected %0d..%0d seen %0d", n, lo, hi, v);
        end
    endtask
    task automatic cyc();
        @(posedge clk);
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        mcu.sfr_read(a, d);
        chk8("sfr_rdata", e, d);
    endtask
    task automatic toggle(input int pin);
        @(posedge clk);
        if (pin == 0) wake_pin_c <= !wake_pin_c;
        else wake_pin_d <= !wake_pin_d;
        #1;
    endtask
    task automatic pulse();
        @(posedge clk);
        energy_pulse_output <= 1'b1;
        @(posedge clk);
        energy_pulse_output <= 1'b0;
        #1;
    endtask
    task automatic go_sleep(input logic light);
        @(posedge clk);
        light_sleep_request <= light;
        deep_sleep_request <= !light;
        cyc();
        cyc();
        chk1("mcu_clk_en", 1'b0, mcu_clk_en);
        chk1("wdt_clk_en", 1'b0, wdt_clk_en);
        chk1("rtc_clk_en", 1'b1, rtc_clk_en);
    endtask
    task automatic no_wake(input int n);
        logic w;
        w = 1'b0;
        repeat (n) begin
            cyc();
            w = w | wake_reset | wake_resume;
        end
        chk1("no wake", 1'b0, w);
    endtask
    task automatic await_wake(input logic rst);
        int i;
        for (i = 0; i < 8; i++) begin
            if (wake_reset === 1'b1 || wake_resume === 1'b1) break;
            cyc();
        end
        chk1("wake_reset", rst, wake_reset);
        chk1("wake_resume", !rst, wake_resume);
        chk1("mcu_clk_en", 1'b1, mcu_clk_en);
        chk1("clear_sleep_ctl", 1'b1, clear_sleep_ctl);
        @(posedge clk);
        light_sleep_request <= 1'b0;
        deep_sleep_request <= 1'b0;
        repeat (3) cyc();
        chk1("clear_sleep_ctl", 1'b0, clear_sleep_ctl);
    endtask
    task automatic reg_case();
        rchk(wcc_pkg::ADDR_RTC_SEL, 8'h00);
        rchk(wcc_pkg::ADDR_IO_WAKE, 8'h00);
        rchk(wcc_pkg::ADDR_SEC_INT, 8'h00);
        mcu.sfr_write(wcc_pkg::ADDR_IO_WAKE, 8'hFF);
        rchk(wcc_pkg::ADDR_IO_WAKE, 8'h07);
        mcu.sfr_write(wcc_pkg::ADDR_RTC_SEL, 8'hA5);
        rchk(wcc_pkg::ADDR_RTC_SEL, 8'hA5);
        mcu.sfr_write(wcc_pkg::ADDR_SEC_INT, 8'h7F);
        rchk(wcc_pkg::ADDR_SEC_INT, 8'h7F);
        mcu.sfr_write(8'h55, 8'h12);
        rchk(8'h55, 8'h00);
        chk1("mcu_clk_en", 1'b1, mcu_clk_en);
        chk1("meter_clk_en", 1'b1, meter_clk_en);
        chk1("lcd_clk_en", 1'b1, lcd_clk_en);
    endtask
    task automatic clock_table();
        logic [4:0] v;
        logic ms, ts;
        for (int i = 0; i < 32; i++) begin
            v = i[4:0];
            @(posedge clk);
            {lcd_gate_req, meter_gate_req, meter_sel_pll_req, mcu_sel_pll_req} <= v[4:1];
            pll_enable_req <= v[0];
            cyc();
            cyc();
            ms = v[1] & v[0];
            ts = v[2] & v[0];
            chk1("pll_enable", v[0], pll_enable);
            chk1("mcu_sel_pll", ms, mcu_sel_pll);
            chk1("meter_sel_pll", ts, meter_sel_pll);
            chk1("meter_clk_en", !v[3], meter_clk_en);
            chk1("lcd_clk_en", !(v[4] & ms & ts), lcd_clk_en);
            chk1("wdt_clk_en", 1'b1, wdt_clk_en);
        end
    endtask
    task automatic pin_case(input int pin, input logic [1:0] code, input logic [7:0] io);
        mcu.sfr_write(wcc_pkg::ADDR_IO_WAKE, io);
        @(posedge clk);
        wake_edge_c <= code;
        wake_edge_d <= code;
        if (pin == 0) wake_pin_c <= (code == 2'h1 || code == 2'h2);
        else wake_pin_d <= (code == 2'h1 || code == 2'h2);
        go_sleep(pin == 0);
        toggle(pin);
        if (code != wcc_pkg::EDGE_BOTH) begin
            no_wake(6);
            toggle(pin);
        end
        await_wake(!io[0]);
    endtask
    task automatic energy_case();
        mcu.sfr_write(wcc_pkg::ADDR_IO_WAKE, 8'h01);
        go_sleep(1'b1);
        pulse();
        toggle(0);
        no_wake(8);
        mcu.sfr_write(wcc_pkg::ADDR_IO_WAKE, 8'h04);
        pulse();
        await_wake(1'b0);
    endtask
    task automatic rtc_case(input logic [7:0] sel, input logic [7:0] sec, input int ticks);
        int n;
        n = 0;
        mcu.sfr_write(wcc_pkg::ADDR_SEC_INT, 8'h00);
        mcu.sfr_write(wcc_pkg::ADDR_RTC_SEL, 8'h03);
        go_sleep(1'b1);
        mcu.sfr_write(wcc_pkg::ADDR_RTC_SEL, sel);
        if (sec[6]) mcu.sfr_write(wcc_pkg::ADDR_SEC_INT, sec);
        while (n < ticks * TC + 40 && rtc_wake_event !== 1'b1) begin
            cyc();
            n++;
        end
        chkr("rtc period", ticks * TC - TC - 2, ticks * TC + TC + 2, n);
        await_wake(1'b0);
    endtask
    task automatic xtal_case();
        chk1("crystal_fail_flag", 1'b0, crystal_fail_flag);
        @(posedge clk);
        crystal_running <= 1'b0;
        repeat (48) cyc();
        chk1("crystal_fail_flag", 1'b0, crystal_fail_flag);
        repeat (80) cyc();
        chk1("crystal_fail_flag", 1'b1, crystal_fail_flag);
        chk1("osc_src_rc", 1'b1, osc_src_rc);
        chk1("crystal_kick", 1'b1, crystal_kick);
        chk8("analog_state_reg", 8'h80, analog_state_reg);
        @(posedge clk);
        crystal_running <= 1'b1;
        repeat (10) cyc();
        chk1("osc_src_rc", 1'b0, osc_src_rc);
        chk8("analog_state_reg", 8'h00, analog_state_reg);
    endtask

    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    initial begin
        sys_rst = 1'b1;
        crystal_running = 1'b1;
        {energy_pulse_output, wake_pin_c, wake_pin_d, wake_edge_c, wake_edge_d} = 7'h00;
        {light_sleep_request, deep_sleep_request, pll_enable_req} = 3'h0;
        {mcu_sel_pll_req, meter_sel_pll_req, meter_gate_req, lcd_gate_req} = 4'h0;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        reg_case();
        clock_table();
        @(posedge clk);
        {lcd_gate_req, meter_gate_req, meter_sel_pll_req, mcu_sel_pll_req} <= 4'h0;
        pll_enable_req <= 1'b0;
        mcu.sfr_write(wcc_pkg::ADDR_SEC_INT, 8'h00);
        mcu.sfr_write(wcc_pkg::ADDR_RTC_SEL, 8'h03);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                pin_case(p, c[1:0], 8'h02);
            end
        end
        pin_case(0, wcc_pkg::EDGE_BOTH, 8'h03);
        energy_case();
        rtc_case(8'h00, 8'h00, 16);
        rtc_case(8'h01, 8'h00, 960);
        rtc_case(8'h04, 8'h00, 8);
        rtc_case(8'h05, 8'h00, 4);
        rtc_case(8'h06, 8'h00, 2);
        rtc_case(8'h07, 8'h00, 1);
        rtc_case(8'h07, 8'h40, 1);
        rtc_case(8'h07, 8'h41, 32);
        rtc_case(8'h07, 8'h43, 64);
        xtal_case();
        close_out();
    end
endmodule // testbench
